//--- logic/lo_ctrl_pkg.sv
// constants, enums and carriers for the local oscillator and mode controller
// assumes a 10 MHz system clock and an open-drain two-wire link to the synthesizer
package lo_ctrl_pkg;
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned I2C_HZ      = 400_000;
    localparam int unsigned I2C_QTR     = (CLK_HZ + 4 * I2C_HZ - 1) / (4 * I2C_HZ);
    localparam int unsigned REF_HZ      = 25_000_000;
    localparam int unsigned SAMPLE_RATE = 48_000;
    localparam int unsigned MCLK_RATIO  = 512;
    localparam int unsigned ADC_MCLK_HZ = MCLK_RATIO * SAMPLE_RATE;
    localparam int unsigned USB_HZ      = 48_000_000;
    localparam int unsigned CPU_HZ      = 72_000_000;
    localparam int unsigned PLL_IN_DIV  = 25;
    localparam int unsigned PLL_VCO_HZ  = 288_000_000;
    localparam logic [6:0]  SYNTH_ADDR  = 7'h60;
    localparam logic [7:0]  OUT_DIV     = 8'h08;
    localparam logic [7:0]  REG_OE      = 8'h03;
    localparam logic [7:0]  REG_FREQ0   = 8'h1a;
    localparam logic [7:0]  REG_PHASE_B = 8'ha6;
    localparam logic [7:0]  REG_CTRL_B  = 8'h11;
    localparam logic [7:0]  OE_TEST_OFF = 8'h04;
    localparam logic [7:0]  CTRL_B_BASE = 8'h0c;
    localparam int unsigned INV_BIT     = 4;
    localparam logic [3:0]  N_WRITES    = 4'h7;
    localparam int unsigned TONE_W      = 24;

    typedef enum logic [1:0] {M_RX, M_ENTER, M_TX, M_LEAVE} mode_e;
    typedef enum logic [2:0] {I_IDLE, I_START, I_BIT, I_STOP} i2c_e;

    typedef struct packed {
        logic        tx;
        logic        test_gen;
        logic [31:0] freq;
    } synth_cfg_s;

    typedef struct packed {
        logic [7:0]  pll_in_div;
        logic [7:0]  cpu_div;
        logic [7:0]  usb_div;
        logic [31:0] adc_mclk_hz;
    } clk_plan_s;
endpackage : lo_ctrl_pkg

//--- logic/lo_mode_ctrl.sv
// local oscillator, transmit/receive mode and clock plan controller
// assumes pins arrive unsynchronised; two-wire pins are open drain, pulled up outside
`timescale 1ns/1ps
`default_nettype none
module lo_mode_ctrl
    import lo_ctrl_pkg::*;
(
    input  wire logic        clk,          // 10 MHz
    input  wire logic        reset,        // sync, active high
    input  wire logic        tx_request,   // pin: high asks for transmit
    input  wire logic        diag_request, // pin: high asks for test generator
    input  wire logic        audio_in,     // pin: squared audio tone
    input  wire logic [31:0] base_freq,    // dial frequency in Hz
    input  wire logic        scl_in,       // clock line level
    input  wire logic        sda_in,       // data line level
    output logic             scl_oe,       // high pulls clock line low
    output logic             sda_oe,       // high pulls data line low
    output logic             rx_isolate,   // high isolates receiver path
    output logic             dsp_suspend,  // high stops I/Q processing
    output logic             pa_drive_en,  // high lets push-pull drive run
    output logic             synth_busy,   // write sequence in progress
    output logic             synth_nack,   // sticky: a byte was not acked
    output logic [TONE_W-1:0] tone_hz,     // last measured tone
    output clk_plan_s        clk_plan      // on-chip clock plan
);
    // ---- pin synchronisers and tone measurement ----
    logic [3:0] s1_q, s1_d, s2_q, s2_d;
    logic       aud_old_q, aud_old_d;
    logic [TONE_W-1:0] per_q, per_d, dvs_q, dvs_d, rem_q, rem_d, quo_q, quo_d, tone_q, tone_d;
    logic [4:0] dcnt_q, dcnt_d;
    logic       dbusy_q, dbusy_d;
    logic       tx_s, diag_s, aud_s, sda_s;
    logic [TONE_W:0] rem_sh;
    localparam logic [TONE_W-1:0] DIVIDEND = TONE_W'(CLK_HZ);

    assign tx_s   = s2_q[0];
    assign diag_s = s2_q[1];
    assign aud_s  = s2_q[2];
    assign sda_s  = s2_q[3];

    always_comb
    begin
        s1_d      = {sda_in, audio_in, diag_request, tx_request};
        s2_d      = s1_q;
        aud_old_d = aud_s;
        per_d     = (per_q == '1) ? per_q : per_q + 1'b1;
        dvs_d     = dvs_q;
        rem_d     = rem_q;
        quo_d     = quo_q;
        dcnt_d    = dcnt_q;
        dbusy_d   = dbusy_q;
        tone_d    = tone_q;
        rem_sh    = {rem_q, DIVIDEND[dcnt_q]};
        if (aud_s && !aud_old_q)
        begin
            per_d = '0;
            if (!dbusy_q)
            begin
                // one full tone cycle measured; start f = clk / period
                dvs_d   = per_q + 1'b1;
                rem_d   = '0;
                quo_d   = '0;
                dcnt_d  = 5'(TONE_W - 1);
                dbusy_d = 1'b1;
            end
        end
        if (dbusy_q)
        begin
            if (rem_sh >= {1'b0, dvs_q})
            begin
                rem_d = TONE_W'(rem_sh - {1'b0, dvs_q});
                quo_d = {quo_q[TONE_W-2:0], 1'b1};
            end
            else
            begin
                rem_d = rem_sh[TONE_W-1:0];
                quo_d = {quo_q[TONE_W-2:0], 1'b0};
            end
            dcnt_d = dcnt_q - 1'b1;
            if (dcnt_q == '0)
            begin
                dbusy_d = 1'b0;
                tone_d  = quo_d;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s1_q <= '0; s2_q <= '0; aud_old_q <= 1'b0; per_q <= '0; dvs_q <= '0;
            rem_q <= '0; quo_q <= '0; dcnt_q <= '0; dbusy_q <= 1'b0; tone_q <= '0;
        end
        else
        begin
            s1_q <= s1_d; s2_q <= s2_d; aud_old_q <= aud_old_d; per_q <= per_d;
            dvs_q <= dvs_d; rem_q <= rem_d; quo_q <= quo_d; dcnt_q <= dcnt_d;
            dbusy_q <= dbusy_d; tone_q <= tone_d;
        end
    end

    // ---- mode sequencing ----
    mode_e      mode_q, mode_d;
    synth_cfg_s want, cfg_q, cfg_d;
    logic       seq_start, seq_synced;
    i2c_e       ist_q, ist_d;

    always_comb
    begin
        want.tx       = (mode_q == M_ENTER) || (mode_q == M_TX);
        want.test_gen = diag_s && (mode_q == M_RX);
        want.freq     = want.tx ? base_freq + 32'(tone_q) : base_freq;
        seq_synced    = (ist_q == I_IDLE) && (want == cfg_q);
        seq_start     = (ist_q == I_IDLE) && (want != cfg_q);
        cfg_d         = seq_start ? want : cfg_q;
        mode_d        = mode_q;
        case (mode_q)
            M_RX:    if (tx_s) mode_d = M_ENTER;
            M_ENTER: if (seq_synced) mode_d = M_TX;
            M_TX:    if (!tx_s) mode_d = M_LEAVE;
            M_LEAVE: if (seq_synced) mode_d = M_RX;
            default: mode_d = M_RX;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mode_q      <= M_RX;
            cfg_q       <= '0;
            rx_isolate  <= 1'b0;
            dsp_suspend <= 1'b0;
            pa_drive_en <= 1'b0;
            clk_plan    <= '0;
            tone_hz     <= '0;
        end
        else
        begin
            mode_q      <= mode_d;
            cfg_q       <= cfg_d;
            rx_isolate  <= (mode_d != M_RX);
            dsp_suspend <= (mode_d != M_RX);
            pa_drive_en <= (mode_d == M_TX);
            clk_plan    <= '{pll_in_div:  8'(PLL_IN_DIV),
                             cpu_div:     8'(PLL_VCO_HZ / CPU_HZ),
                             usb_div:     8'(PLL_VCO_HZ / USB_HZ),
                             adc_mclk_hz: 32'(ADC_MCLK_HZ)};
            tone_hz     <= tone_q;
        end
    end

    // ---- two-wire write engine ----
    logic [2:0] qc_q, qc_d;
    logic [1:0] ph_q, ph_d, by_q, by_d;
    logic [3:0] bit_q, bit_d, wr_q, wr_d;
    logic       scl_d, sda_d, nack_d, slot_end;
    logic [7:0] cur_byte, reg_a, reg_v;

    always_comb
    begin
        reg_a = REG_OE;
        reg_v = cfg_q.test_gen ? 8'h00 : OE_TEST_OFF;
        if (wr_q >= 4'h1 && wr_q <= 4'h4)
        begin
            reg_a = REG_FREQ0 + 8'(wr_q - 4'h1);
            reg_v = cfg_q.freq[8*(wr_q - 4'h1) +: 8];
        end
        else if (wr_q == 4'h5)
        begin
            reg_a = REG_PHASE_B;
            reg_v = cfg_q.tx ? 8'h00 : OUT_DIV;
        end
        else if (wr_q == 4'h6)
        begin
            reg_a = REG_CTRL_B;
            reg_v = CTRL_B_BASE | (cfg_q.tx ? 8'(1 << INV_BIT) : 8'h00);
        end
        cur_byte = (by_q == 2'd0) ? {SYNTH_ADDR, 1'b0} : (by_q == 2'd1) ? reg_a : reg_v;
    end

    always_comb
    begin
        slot_end = (qc_q == 3'(I2C_QTR - 1)) && (ph_q == 2'd3);
        qc_d     = (ist_q == I_IDLE || qc_q == 3'(I2C_QTR - 1)) ? 3'h0 : qc_q + 1'b1;
        ph_d     = (ist_q == I_IDLE) ? 2'd0 : (qc_q == 3'(I2C_QTR - 1)) ? ph_q + 1'b1 : ph_q;
        ist_d    = ist_q;
        bit_d    = bit_q;
        by_d     = by_q;
        wr_d     = wr_q;
        nack_d   = synth_nack;
        scl_d    = 1'b0;
        sda_d    = 1'b0;
        case (ist_q)
            I_IDLE:
            begin
                wr_d = '0;
                if (seq_start) ist_d = I_START;
            end
            I_START:
            begin
                sda_d = (ph_q >= 2'd2);
                scl_d = (ph_q == 2'd3);
                if (slot_end)
                begin
                    ist_d = I_BIT;
                    bit_d = '0;
                    by_d  = '0;
                end
            end
            I_BIT:
            begin
                scl_d = (ph_q == 2'd0) || (ph_q == 2'd3);
                sda_d = (bit_q != 4'd8) && !cur_byte[3'(4'd7 - bit_q)];
                if (bit_q == 4'd8 && ph_q == 2'd2 && qc_q == 3'(I2C_QTR - 1) && sda_s)
                    nack_d = 1'b1;
                if (slot_end)
                begin
                    bit_d = bit_q + 1'b1;
                    if (bit_q == 4'd8)
                    begin
                        bit_d = '0;
                        by_d  = by_q + 1'b1;
                        if (by_q == 2'd2) ist_d = I_STOP;
                    end
                end
            end
            I_STOP:
            begin
                scl_d = (ph_q == 2'd0);
                sda_d = (ph_q <= 2'd1);
                if (slot_end)
                begin
                    wr_d  = wr_q + 1'b1;
                    ist_d = (wr_q == N_WRITES - 1'b1) ? I_IDLE : I_START;
                end
            end
            default: ist_d = I_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ist_q <= I_IDLE; qc_q <= '0; ph_q <= '0; bit_q <= '0; by_q <= '0; wr_q <= '0;
            scl_oe <= 1'b0; sda_oe <= 1'b0; synth_busy <= 1'b0; synth_nack <= 1'b0;
        end
        else
        begin
            ist_q <= ist_d; qc_q <= qc_d; ph_q <= ph_d; bit_q <= bit_d; by_q <= by_d;
            wr_q <= wr_d; scl_oe <= scl_d; sda_oe <= sda_d;
            synth_busy <= (ist_d != I_IDLE);
            synth_nack <= nack_d;
        end
    end

    // scl_in is released-line feedback only; no clock stretching is honoured
    logic unused_ok;
    assign unused_ok = scl_in;

    // ---- checks ----
    a_rx_drive_zero: assert property (@(posedge clk) disable iff (reset)
        (mode_q == M_RX) |-> !pa_drive_en) else $error("drive active in receive");
    a_tx_path_isolated: assert property (@(posedge clk) disable iff (reset)
        pa_drive_en |-> rx_isolate && dsp_suspend) else $error("drive without isolation");
    a_enter_order: assert property (@(posedge clk) disable iff (reset)
        $rose(pa_drive_en) |-> $past(rx_isolate) && cfg_q.tx) else $error("drive before isolate");
    a_leave_order: assert property (@(posedge clk) disable iff (reset)
        $fell(rx_isolate) |-> !pa_drive_en && $past(!pa_drive_en)) else $error("reconnect under drive");
    a_start_when_idle: assert property (@(posedge clk) disable iff (reset)
        seq_start |=> (ist_q == I_START) && synth_busy) else $error("sequence start lost");
    a_test_gen_rx: assert property (@(posedge clk) disable iff (reset)
        cfg_q.test_gen |-> !cfg_q.tx) else $error("test generator on in transmit");
    a_phase_quad: assert property (@(posedge clk) disable iff (reset)
        (ist_q == I_BIT && wr_q == 4'h5 && by_q == 2'd2 && !cfg_q.tx) |-> cur_byte == OUT_DIV)
        else $error("quadrature offset wrong");
    a_phase_invert: assert property (@(posedge clk) disable iff (reset)
        (ist_q == I_BIT && wr_q == 4'h6 && by_q == 2'd2) |-> cur_byte[INV_BIT] == cfg_q.tx)
        else $error("invert bit wrong");
    a_addr_byte: assert property (@(posedge clk) disable iff (reset)
        (ist_q == I_BIT && by_q == 2'd0) |-> cur_byte == {SYNTH_ADDR, 1'b0})
        else $error("bad device address");
    a_scl_high_time: assert property (@(posedge clk) disable iff (reset)
        (ist_q == I_BIT && $fell(scl_oe)) |-> !scl_oe [*8]) else $error("scl high too short");
    a_even_div: assert property (@(posedge clk) disable iff (reset)
        (ist_q == I_BIT && wr_q == 4'h5 && by_q == 2'd2) |-> !cur_byte[0])
        else $error("odd output divider");
    a_tone_carrier: assert property (@(posedge clk) disable iff (reset)
        (seq_start && want.tx) |=> cfg_q.freq == $past(base_freq) + 32'($past(tone_q)))
        else $error("carrier not base plus tone");

    c_enter_tx: cover property (@(posedge clk) disable iff (reset) $rose(pa_drive_en));
    c_leave_tx: cover property (@(posedge clk) disable iff (reset) $fell(rx_isolate));
    c_diag_write: cover property (@(posedge clk) disable iff (reset) seq_start && want.test_gen);
    c_tone_done: cover property (@(posedge clk) disable iff (reset) $fell(dbusy_q));
endmodule : lo_mode_ctrl
`default_nettype wire

//--- test/synth_model.sv
// two-wire synthesizer model: acknowledges writes and keeps its 8-bit registers
// assumes resolved, pulled-up clock and data lines from the bench; no clock stretching
`timescale 1ns/1ps
`default_nettype none
module synth_model
    import lo_ctrl_pkg::*;
(
    input  wire logic scl,       // resolved clock line
    input  wire logic sda,       // resolved data line
    input  wire logic nack_mode, // high: never acknowledge
    output logic      sda_pull   // high pulls data line low
);
    logic [7:0] regs [256];
    logic [7:0] sh;
    logic [7:0] ptr;
    int         nbit;
    int         nbyte;

    initial sda_pull = 1'b0;
    // start condition: data falls while clock high
    always @(negedge sda) if (scl === 1'b1)
    begin
        nbit = 0;
        nbyte = 0;
    end
    always @(posedge scl) if (nbit < 8)
    begin
        sh = {sh[6:0], sda};
        nbit++;
    end
    // ack driven from the 8th clock fall until the 9th, then released to the pull-up
    always @(negedge scl)
    begin
        if (nbit == 8)
        begin
            if (nbyte == 1)
                ptr = sh;
            else if (nbyte > 1)
            begin
                regs[ptr] = sh;
                ptr++;
            end
            sda_pull <= !nack_mode && (nbyte > 0 || sh[7:1] == SYNTH_ADDR);
            nbit = 9;
            nbyte++;
        end
        else if (nbit == 9)
        begin
            sda_pull <= 1'b0;
            nbit = 0;
        end
    end
endmodule : synth_model
`default_nettype wire

//--- test/test_transceiver_lo_and_mode_control.sv
// bench for the oscillator and mode controller with a synthesizer model on the two-wire link
// assumes the line pull-ups are modelled here by resolving the open-drain enables
`timescale 1ns/1ps
`default_nettype none
module test_transceiver_lo_and_mode_control
    import lo_ctrl_pkg::*;
;
    typedef struct packed {
        logic       tx;
        logic       diag;
        logic [7:0] oe;
        logic [7:0] ph;
        logic [7:0] ctl;
    } row_s;
    localparam int TONE  = 10_000_000 / 8;
    localparam int LIMIT = 90_000;

    logic              clk, reset, tx_request, diag_request, audio_in, nack_mode, sda_pull;
    logic [31:0]       base_freq;
    logic              scl_oe, sda_oe, rx_isolate, dsp_suspend, pa_drive_en;
    logic              synth_busy, synth_nack;
    logic [TONE_W-1:0] tone_hz;
    clk_plan_s         clk_plan;
    int                mismatches, n_checks, cycles, order_bad, scl_cnt, min_per;
    wire               scl_line = !scl_oe;
    wire               sda_line = !(sda_oe || sda_pull);
    logic              scl_last;
    row_s              rows [5] = '{
        '{1'b0, 1'b0, OE_TEST_OFF, OUT_DIV, CTRL_B_BASE},
        '{1'b0, 1'b1, 8'h00, OUT_DIV, CTRL_B_BASE},
        '{1'b1, 1'b1, OE_TEST_OFF, 8'h00, CTRL_B_BASE | 8'h10},
        '{1'b1, 1'b0, OE_TEST_OFF, 8'h00, CTRL_B_BASE | 8'h10},
        '{1'b0, 1'b0, OE_TEST_OFF, OUT_DIV, CTRL_B_BASE}};

    lo_mode_ctrl u_dut (.clk(clk), .reset(reset), .tx_request(tx_request),
        .diag_request(diag_request), .audio_in(audio_in), .base_freq(base_freq),
        .scl_in(scl_line), .sda_in(sda_line), .scl_oe(scl_oe), .sda_oe(sda_oe),
        .rx_isolate(rx_isolate), .dsp_suspend(dsp_suspend), .pa_drive_en(pa_drive_en),
        .synth_busy(synth_busy), .synth_nack(synth_nack), .tone_hz(tone_hz),
        .clk_plan(clk_plan));
    synth_model u_synth (.scl(scl_line), .sda(sda_line), .nack_mode(nack_mode),
        .sda_pull(sda_pull));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // tone of 800 ns period, phase unrelated to the clock
    initial
    begin
        audio_in = 1'b0;
        #37;
        forever #400 audio_in = ~audio_in;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : cyc

    // no write may start once the link has stayed idle this long
    task automatic settle;
        int idle;
        idle = 0;
        cyc(5);
        while (idle < 200)
        begin
            idle = (synth_busy === 1'b0) ? idle + 1 : 0;
            cyc(1);
        end
    endtask : settle

    function automatic logic [31:0] got_freq();
        return {u_synth.regs[REG_FREQ0 + 3], u_synth.regs[REG_FREQ0 + 2],
                u_synth.regs[REG_FREQ0 + 1], u_synth.regs[REG_FREQ0]};
    endfunction : got_freq

    task automatic check_cfg(input row_s r);
        chk("test_gen_oe", u_synth.regs[REG_OE], r.oe);
        chk("phase_b", u_synth.regs[REG_PHASE_B], r.ph);
        chk("ctrl_b", u_synth.regs[REG_CTRL_B], r.ctl);
        chk("freq", got_freq(), base_freq + (r.tx ? TONE : 0));
        chk("pa_drive_en", pa_drive_en, r.tx);
        chk("rx_isolate", rx_isolate, r.tx);
        chk("dsp_suspend", dsp_suspend, r.tx);
        chk("bus_idle", {scl_oe, sda_oe}, 2'b00);
    endtask : check_cfg

    // watchers: drive only while isolated, and link clock period
    // sampled on the falling edge so registered outputs have settled
    always @(negedge clk)
    begin
        cycles++;
        scl_cnt++;
        if (!reset && pa_drive_en && !rx_isolate)
            order_bad++;
        if (!reset && dsp_suspend !== rx_isolate)
            order_bad++;
        if (scl_last && !scl_line)
        begin
            if (scl_cnt < min_per)
                min_per = scl_cnt;
            scl_cnt = 0;
        end
        scl_last = scl_line;
        if (cycles == LIMIT)
        begin
            mismatches++;
            end_of_test();
        end
    end

    initial
    begin
        min_per = 1000;
        scl_cnt = 1000;
        scl_last = 1'b1;
        reset = 1'b1;
        tx_request = 1'b0;
        diag_request = 1'b0;
        nack_mode = 1'b0;
        base_freq = 32'h006b_f0b0;
        cyc(16);
        chk("plan_in_reset", clk_plan, 56'h0);
        reset = 1'b0;
        settle();
        chk("clk_plan", clk_plan, {8'h19, 8'(PLL_VCO_HZ / CPU_HZ), 8'(PLL_VCO_HZ / USB_HZ),
            32'(512 * 48_000)});
        chk("tone_hz", tone_hz, TONE);
        for (int i = 0; i < 5; i++)
        begin
            tx_request = rows[i].tx;
            diag_request = rows[i].diag;
            settle();
            check_cfg(rows[i]);
        end
        chk("even_divider", u_synth.regs[REG_PHASE_B][0], 1'b0);
        // retune in mid-sequence: the later value must win
        base_freq = 32'h0035_0000;
        cyc(300);
        chk("busy_mid", synth_busy, 1'b1);
        base_freq = 32'h0036_0000;
        settle();
        chk("freq_retune", got_freq(), base_freq);
        nack_mode = 1'b1;
        base_freq = 32'h0037_0000;
        settle();
        chk("nack", synth_nack, 1'b1);
        // reset while entering transmit
        tx_request = 1'b1;
        cyc(40);
        reset = 1'b1;
        cyc(2);
        chk("outs_in_reset", {scl_oe, sda_oe, rx_isolate, dsp_suspend, pa_drive_en,
            synth_busy, synth_nack, clk_plan}, 63'h0);
        tx_request = 1'b0;
        nack_mode = 1'b0;
        reset = 1'b0;
        settle();
        check_cfg(rows[0]);
        chk("nack_cleared", synth_nack, 1'b0);
        chk("order", order_bad, 0);
        chk("scl_rate", min_per >= 25, 1'b1);
        end_of_test();
    end
endmodule : test_transceiver_lo_and_mode_control
`default_nettype wire
